/* File: sbc_cfg.svh */
/*
 * Constants of the status-decoding bus command controller: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock.
 */
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

`define SBC_CLK_PERIOD_NS   10
`define SBC_GRANT_MIN_NS    110
`define SBC_GRANT_MAX_NS    250
// Least delay rounds up to whole cycles.
`define SBC_GRANT_CYC       ((`SBC_GRANT_MIN_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)

`define SBC_CTRL_OFFSET     12'h000
`define SBC_STATUS_OFFSET   12'h004
`define SBC_CTRL_SOFT_EN    0
`define SBC_CTRL_RESET      32'h0000_0001

`define SBC_ST_CODE_LSB     0
`define SBC_ST_MODE_BIT     3
`define SBC_ST_GRANT_BIT    4
`define SBC_ST_BUSY_BIT     5

`define SBC_CODE_IRQ_ACK_STROBE_N       3'h0
`define SBC_CODE_IORD       3'h1
`define SBC_CODE_IOWR       3'h2
`define SBC_CODE_HALT       3'h3
`define SBC_CODE_CODE       3'h4
`define SBC_CODE_MRD        3'h5
`define SBC_CODE_MWR        3'h6
`define SBC_CODE_PASSIVE    3'h7

`endif

/* File: sbc_pkg.sv */
/*
 * Types of the status-decoding bus command controller.
 * Assumes sbc_cfg.svh for all numeric constants.
 */
package sbc_pkg;

	typedef enum logic [1:0] {SBC_IDLE, SBC_ADDR, SBC_DATA} sbc_state_type;

	// Active-high decode of one status code, one bit per command strobe.
	typedef struct packed {
		logic irq_ack_strobe_n;
		logic iord;
		logic iowr;
		logic aiowr;
		logic mrd;
		logic mwr;
		logic amwr;
	} sbc_cmd_type;

endpackage : sbc_pkg

/* File: sbc_controller.sv */
/*
 * Bus command controller: decodes the processor status code into command
 * strobes, address latch strobe and transceiver controls; AHB-Lite slave
 * for a small control and status block.
 * Assumes the status code, grant, qualify and strap arrive asynchronously
 * on pins and that the processor shares this clock's timing.
 */
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
// Operation
// RULE1 - Status 000 ack, 001 IO read, 010 IO write, 011 halt, 10x/110 memory, 111 passive.
// RULE2 - Early memory write strobe falls before the normal memory write strobe.
// RULE3 - Both early write strobes assert with read strobe timing.
// RULE4 - All seven command strobes are active low.
// RULE5 - Interrupt acknowledge behaves as an IO read during interrupt cycles.
// RULE6 - Strap high selects IO bus mode, low system bus mode; static.
// RULE7 - IO bus mode: IO strobes ignore the grant; peripheral enable and direction.
// RULE8 - IO bus mode: memory strobes still wait for the grant.
// RULE9 - System bus mode: no strobe until a delay after grant.
// RULE10 - Commands enabled 110 ns to 250 ns after grant falls.
// RULE11 - Gated command drivers float as soon as grant goes high.
// RULE12 - Data enable gates the transceiver, direction sets its way.
// RULE13 - Direction high for writes, low for reads.
// RULE14 - Shared enable pin: cascade in system mode, peripheral enable in IO mode.
// RULE15 - System mode: cascade enable high during interrupt acknowledge.
// RULE16 - IO mode: peripheral data enable is active low.
// RULE17 - Interrupt sequence is two back-to-back acknowledges; cascade enable before second.
// RULE18 - System logic masks cascade enable during the first acknowledge.
// RULE19 - Address latch strobe pulses once every machine cycle.
// RULE20 - Address latch strobe is active high; latches close on its fall.
// RULE21 - Qualify low holds all strobes driven inactive, not floating.
// RULE22 - IO strobes in IO bus mode must not drive a shared bus.
// RULE23 - Cycle starts when status leaves passive, ends when it returns.
`timescale 1ns/100ps
`include "sbc_cfg.svh"

module sbc_controller
	import sbc_pkg::*;
(
	input  wire logic        clk_in,                       // Core clock
	input  wire logic        rstn_in,                      // Async reset, low
	input  wire logic        status_bit_zero_in,           // Status code bit 0
	input  wire logic        status_bit_one_in,            // Status code bit 1
	input  wire logic        status_bit_two_in,            // Status code bit 2
	input  wire logic        bus_grant_n_in,               // Bus grant, low
	input  wire logic        command_qualify_in,           // Command qualify
	input  wire logic        io_bus_mode_strap_in,         // Mode strap
	input  wire logic        hsel_in,                      // AHB select
	input  wire logic [31:0] haddr_in,                     // AHB address
	input  wire logic [1:0]  htrans_in,                    // AHB transfer type
	input  wire logic        hwrite_in,                    // AHB write
	input  wire logic [2:0]  hsize_in,                     // AHB size
	input  wire logic [31:0] hwdata_in,                    // AHB write data
	input  wire logic        hready_in,                    // AHB ready in
	output logic      [31:0] hrdata_out,                   // AHB read data
	output logic             hreadyout_out,                // AHB ready out
	output logic             hresp_out,                    // AHB response
	output logic             mem_read_strobe_n_out,        // Memory read
	output logic             mem_write_strobe_n_out,       // Memory write
	output logic             early_mem_write_strobe_n_out, // Early memory write
	output logic             io_read_strobe_n_out,         // IO read
	output logic             io_write_strobe_n_out,        // IO write
	output logic             early_io_write_strobe_n_out,  // Early IO write
	output logic             irq_ack_strobe_n_out,         // Interrupt acknowledge
	output logic             mem_cmd_oe_out,               // Memory strobe drive enable
	output logic             io_cmd_oe_out,                // IO strobe drive enable
	output logic             addr_latch_strobe_out,        // Address latch strobe
	output logic             xcvr_enable_out,              // Transceiver enable
	output logic             xfer_direction_out,           // High transmit
	output logic             cascade_or_periph_enable_out  // Cascade or periph enable
);

	// ==========================================================
	// Decode
	// ==========================================================
	function automatic sbc_cmd_type decode_cmd(input logic [2:0] code);
		sbc_cmd_type c;
		c = '0;
		unique case (code)
			`SBC_CODE_IRQ_ACK_STROBE_N: c.irq_ack_strobe_n = 1'b1;
			`SBC_CODE_IORD: c.iord = 1'b1;
			`SBC_CODE_IOWR:
			begin
				c.iowr  = 1'b1;
				c.aiowr = 1'b1;
			end
			`SBC_CODE_CODE,
			`SBC_CODE_MRD:  c.mrd = 1'b1;
			`SBC_CODE_MWR:
			begin
				c.mwr  = 1'b1;
				c.amwr = 1'b1;
			end
			`SBC_CODE_HALT,
			`SBC_CODE_PASSIVE: c = '0;
		endcase
		return c;
	endfunction : decode_cmd

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [5:0] pin_raw;
	logic [5:0] pin_meta_q;
	logic [5:0] pin_sync_q;

	assign pin_raw = {io_bus_mode_strap_in, command_qualify_in, bus_grant_n_in,
	                  status_bit_two_in, status_bit_one_in, status_bit_zero_in};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_sync
			always_ff @(posedge clk_in or negedge rstn_in)
			begin
				if (!rstn_in)
				begin
					pin_meta_q[gi] <= 1'b1;
					pin_sync_q[gi] <= 1'b1;
				end
				else
				begin
					pin_meta_q[gi] <= pin_raw[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
				end
			end
		end
	endgenerate

	logic [2:0] code;
	logic       grant_low;
	logic       qualify;
	assign code      = pin_sync_q[2:0];
	assign grant_low = ~pin_sync_q[3];
	assign qualify   = pin_sync_q[4];

	// ==========================================================
	// Mode strap, caught once after reset release
	// ==========================================================
	logic       mode_iob_q;
	logic [1:0] strap_wait_q;

	// The synchronisers leave reset at one, so the strap is taken only once they have flushed.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			mode_iob_q   <= 1'b0;
			strap_wait_q <= 2'h0;
		end
		else if (strap_wait_q != 2'h3)
		begin
			mode_iob_q   <= (strap_wait_q == 2'h2) ? pin_sync_q[5] : mode_iob_q; // RULE6
			strap_wait_q <= strap_wait_q + 2'h1;
		end
	end

	// ==========================================================
	// Grant delay
	// ==========================================================
	logic [4:0] grant_cnt_q;
	logic       grant_ready;
	assign grant_ready = grant_low & (grant_cnt_q == 5'(`SBC_GRANT_CYC)); // RULE11

	// Two synchroniser cycles plus the count keep the delay under the maximum.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			grant_cnt_q <= '0;
		else if (!grant_low)
			grant_cnt_q <= '0; // RULE11
		else if (!grant_ready)
			grant_cnt_q <= grant_cnt_q + 5'h01; // RULE9 RULE10
	end

	// ==========================================================
	// Machine cycle sequencer
	// ==========================================================
	sbc_state_type st_q;
	logic [2:0]    kind_q;

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			st_q   <= SBC_IDLE;
			kind_q <= `SBC_CODE_PASSIVE;
		end
		else
		begin
			unique case (st_q)
				SBC_IDLE:
				if (code != `SBC_CODE_PASSIVE)
				begin
					st_q   <= SBC_ADDR; // RULE23
					kind_q <= code;
				end
				SBC_ADDR: st_q <= SBC_DATA;
				SBC_DATA:
				if (code == `SBC_CODE_PASSIVE)
				begin
					st_q   <= SBC_IDLE; // RULE23
					kind_q <= `SBC_CODE_PASSIVE;
				end
			endcase
		end
	end

	// ==========================================================
	// Command strobes and drive enables
	// ==========================================================
	logic        soft_en_q;
	logic        cmd_en;
	logic        mem_gate;
	logic        io_gate;
	logic        in_data;
	sbc_cmd_type dec;
	sbc_cmd_type cmd_q;

	assign cmd_en   = qualify & soft_en_q; // RULE21
	assign mem_gate = grant_ready; // RULE8 RULE9
	assign io_gate  = mode_iob_q | grant_ready; // RULE7 RULE9
	assign in_data  = (st_q == SBC_DATA);
	assign dec      = decode_cmd(kind_q); // RULE1

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cmd_q          <= '0;
			mem_cmd_oe_out <= 1'b0;
			io_cmd_oe_out  <= 1'b0;
		end
		else
		begin
			cmd_q.irq_ack_strobe_n  <= in_data & cmd_en & io_gate & dec.irq_ack_strobe_n; // RULE5
			cmd_q.iord  <= in_data & cmd_en & io_gate & dec.iord;
			cmd_q.aiowr <= in_data & cmd_en & io_gate & dec.aiowr; // RULE3
			// Normal writes follow their early strobe, so a late grant cannot invert them.
			cmd_q.iowr  <= in_data & cmd_q.aiowr & cmd_en & io_gate & dec.iowr;
			cmd_q.mrd   <= in_data & cmd_en & mem_gate & dec.mrd;
			cmd_q.amwr  <= in_data & cmd_en & mem_gate & dec.amwr; // RULE2 RULE3
			cmd_q.mwr   <= in_data & cmd_q.amwr & cmd_en & mem_gate & dec.mwr; // RULE2
			mem_cmd_oe_out <= mem_gate; // RULE11
			io_cmd_oe_out  <= io_gate; // RULE7 RULE11
		end
	end

	// Strobes stay driven high when inactive; only the enables float them.
	assign irq_ack_strobe_n_out         = ~cmd_q.irq_ack_strobe_n; // RULE4 RULE21
	assign io_read_strobe_n_out         = ~cmd_q.iord;
	assign io_write_strobe_n_out        = ~cmd_q.iowr;
	assign early_io_write_strobe_n_out  = ~cmd_q.aiowr;
	assign mem_read_strobe_n_out        = ~cmd_q.mrd;
	assign mem_write_strobe_n_out       = ~cmd_q.mwr;
	assign early_mem_write_strobe_n_out = ~cmd_q.amwr;

	// ==========================================================
	// Control outputs
	// ==========================================================
	logic is_mem;
	logic is_io;
	logic is_write;
	logic periph_xcvr_enable_n_q;
	logic mce_q;
	assign is_mem   = dec.mrd | dec.mwr;
	assign is_io    = dec.irq_ack_strobe_n | dec.iord | dec.iowr;
	assign is_write = dec.mwr | dec.iowr;

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			addr_latch_strobe_out <= 1'b0;
			xcvr_enable_out       <= 1'b0;
			xfer_direction_out    <= 1'b1;
			periph_xcvr_enable_n_q                <= 1'b0;
			mce_q                 <= 1'b0;
		end
		else
		begin
			addr_latch_strobe_out <= (st_q == SBC_ADDR); // RULE19 RULE20
			xcvr_enable_out <= in_data & cmd_en & (mode_iob_q ? is_mem & mem_gate
			                   : (is_mem | is_io) & grant_ready); // RULE12
			xfer_direction_out <= (st_q == SBC_IDLE) | is_write; // RULE13
			periph_xcvr_enable_n_q <= in_data & cmd_en & mode_iob_q & is_io; // RULE7 RULE16
			// A lone controller still drives this; the first-cycle mask is outside.
			mce_q <= (st_q == SBC_ADDR) & dec.irq_ack_strobe_n & ~mode_iob_q; // RULE15 RULE17
		end
	end

	assign cascade_or_periph_enable_out = mode_iob_q ? ~periph_xcvr_enable_n_q : mce_q; // RULE14

	// ==========================================================
	// AHB-Lite slave
	// ==========================================================
	logic        wr_pend_q;
	logic [11:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic        ahb_go;
	logic [31:0] status_word;

	assign ahb_go      = hsel_in & htrans_in[1] & hready_in;
	assign status_word = {26'h0, st_q != SBC_IDLE, grant_ready, mode_iob_q, kind_q};

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q  <= '0;
		end
		else
		begin
			wr_pend_q <= ahb_go & hwrite_in;
			wr_addr_q <= haddr_in[11:0];
			if (ahb_go && !hwrite_in)
				hrdata_q <= (haddr_in[11:0] == `SBC_CTRL_OFFSET) ? {31'h0, soft_en_q}
				            : (haddr_in[11:0] == `SBC_STATUS_OFFSET) ? status_word : 32'h0;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			soft_en_q <= 1'(`SBC_CTRL_RESET);
		else if (wr_pend_q && wr_addr_q == `SBC_CTRL_OFFSET)
			soft_en_q <= hwdata_in[`SBC_CTRL_SOFT_EN];
	end

	assign hrdata_out    = hrdata_q;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	// ==========================================================
	// Assertions
	// ==========================================================
	property p_ale_pulse;
		@(posedge clk_in) disable iff (!rstn_in)
		(st_q == SBC_IDLE && code != `SBC_CODE_PASSIVE) |=> ##1 addr_latch_strobe_out ##1 !addr_latch_strobe_out;
	endproperty
	a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe not one pulse"); // RULE19

	property p_early_first;
		@(posedge clk_in) disable iff (!rstn_in)
		$fell(mem_write_strobe_n_out) |-> $past(!early_mem_write_strobe_n_out);
	endproperty
	a_early_first: assert property (p_early_first) else $error("write before early write"); // RULE2

	property p_early_io;
		@(posedge clk_in) disable iff (!rstn_in)
		(mode_iob_q && $rose(in_data) && dec.iowr && cmd_en) |=> !early_io_write_strobe_n_out;
	endproperty
	a_early_io: assert property (p_early_io) else $error("early IO write late"); // RULE3 RULE7

	property p_qualify;
		@(posedge clk_in) disable iff (!rstn_in)
		!cmd_en |=> (&{mem_read_strobe_n_out, mem_write_strobe_n_out, irq_ack_strobe_n_out,
		              early_mem_write_strobe_n_out, io_read_strobe_n_out,
		              io_write_strobe_n_out, early_io_write_strobe_n_out});
	endproperty
	a_qualify: assert property (p_qualify) else $error("strobe while unqualified"); // RULE21

	property p_grant_wait;
		@(posedge clk_in) disable iff (!rstn_in)
		$rose(grant_low) |-> !mem_cmd_oe_out [*8];
	endproperty
	a_grant_wait: assert property (p_grant_wait) else $error("memory drive too early"); // RULE10

	property p_grant_max;
		@(posedge clk_in) disable iff (!rstn_in)
		($rose(grant_low) ##1 grant_low [*8] ##1 grant_low [*3]) |=> mem_cmd_oe_out;
	endproperty
	a_grant_max: assert property (p_grant_max) else $error("memory drive too late"); // RULE10

	property p_float;
		@(posedge clk_in) disable iff (!rstn_in)
		(!grant_low && !mode_iob_q) |=> (!mem_cmd_oe_out && !io_cmd_oe_out);
	endproperty
	a_float: assert property (p_float) else $error("drivers on without grant"); // RULE11

	property p_dir;
		@(posedge clk_in) disable iff (!rstn_in)
		(in_data && dec.iord) |=> !xfer_direction_out;
	endproperty
	a_dir: assert property (p_dir) else $error("direction high on read"); // RULE13

	property p_mce;
		@(posedge clk_in) disable iff (!rstn_in)
		(!mode_iob_q && addr_latch_strobe_out && kind_q == `SBC_CODE_IRQ_ACK_STROBE_N)
		|-> cascade_or_periph_enable_out;
	endproperty
	a_mce: assert property (p_mce) else $error("cascade enable missing"); // RULE15

endmodule : sbc_controller

/* File: sbc_cpu_model.sv */
/*
 * Processor and bus arbiter model: drives the status code and the grant.
 * Assumes the bench calls its tasks from the clk_in domain.
 */
`timescale 1ns/100ps

module sbc_cpu_model
(
	input  wire logic clk_in,              // Shared clock
	input  wire logic cascade_enable_in,   // Cascade enable seen
	output logic      status_bit_zero_out, // Status bit 0
	output logic      status_bit_one_out,  // Status bit 1
	output logic      status_bit_two_out,  // Status bit 2
	output logic      bus_grant_n_out,     // Grant, low
	output logic      cascade_masked_out   // Cascade enable, first ack masked
);
	logic ack_odd    = 1'b0;
	logic ack_second = 1'b0;

	assign cascade_masked_out = cascade_enable_in & ack_second;

	initial
	begin
		{status_bit_two_out, status_bit_one_out, status_bit_zero_out} = 3'h7;
		bus_grant_n_out = 1'b1;
	end

	// ==========================================
	// Status and grant
	// The first acknowledge of a pair moves no data, so its cascade enable is masked.
	// IO bus traffic never asks for the shared grant.
	task automatic issue(input logic [2:0] code);
		@(posedge clk_in);
		{status_bit_two_out, status_bit_one_out, status_bit_zero_out} <= code;
		ack_second <= (code == 3'h0) && ack_odd;
		ack_odd    <= (code == 3'h0) && !ack_odd;
	endtask : issue

	// Passive is held three cycles so the next code opens a new cycle.
	task automatic passive();
		@(posedge clk_in);
		{status_bit_two_out, status_bit_one_out, status_bit_zero_out} <= 3'h7;
		repeat (3) @(posedge clk_in);
	endtask : passive

	task automatic grant(input logic g);
		@(posedge clk_in);
		bus_grant_n_out <= !g;
	endtask : grant
endmodule : sbc_cpu_model

/* File: test_cpu_status_bus_command_controller.sv */
/*
 * Self-checking bench for the bus command controller.
 * Assumes the processor model drives status and grant; the bench is AHB master.
 */
`timescale 1ns/100ps
`include "sbc_cfg.svh"

module test_cpu_status_bus_command_controller;
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        cq = 1'b1;
	logic        strap = 1'b0;
	logic        sysm = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire  [6:0]  cmd_n;
	wire         hrdy, hresp, s0, s1, s2, gnt_n, moe, ioe, als, xen, dir, cpe, cpm;
	int          n_errors = 0;
	int          n_tests = 0;

	always #5 clk_in = ~clk_in;

	sbc_cpu_model cpu (.clk_in(clk_in), .cascade_enable_in(cpe), .status_bit_zero_out(s0),
		.status_bit_one_out(s1), .status_bit_two_out(s2), .bus_grant_n_out(gnt_n),
		.cascade_masked_out(cpm));

	sbc_controller dut (.clk_in(clk_in), .rstn_in(rstn_in), .status_bit_zero_in(s0),
		.status_bit_one_in(s1), .status_bit_two_in(s2), .bus_grant_n_in(gnt_n),
		.command_qualify_in(cq), .io_bus_mode_strap_in(strap), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
		.hresp_out(hresp), .irq_ack_strobe_n_out(cmd_n[6]), .io_read_strobe_n_out(cmd_n[5]),
		.io_write_strobe_n_out(cmd_n[4]), .early_io_write_strobe_n_out(cmd_n[3]),
		.mem_read_strobe_n_out(cmd_n[2]), .mem_write_strobe_n_out(cmd_n[1]),
		.early_mem_write_strobe_n_out(cmd_n[0]), .mem_cmd_oe_out(moe), .io_cmd_oe_out(ioe),
		.addr_latch_strobe_out(als), .xcvr_enable_out(xen), .xfer_direction_out(dir),
		.cascade_or_periph_enable_out(cpe));

	// ==========================================
	// Shared tasks
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1)
		begin
			n_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk

	task automatic finish_test();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic ahb(input logic [31:0] a, input logic [31:0] d, input logic w,
		output logic [31:0] r);
		@(posedge clk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk_in);
		while (hrdy !== 1'b1) @(posedge clk_in);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_in);
		while (hrdy !== 1'b1) @(posedge clk_in);
		r = hrdata;
		chk(hresp === 1'b0, "response not okay");
	endtask : ahb

	// Strobes, active low, in the order of cmd_n; the normal writes lag one cycle.
	function automatic logic [6:0] exp_cmd(input logic [2:0] c, input logic full,
		input logic mem, input logic io);
		logic [6:0] v;
		case (c)
			3'h0: v = 7'h40;
			3'h1: v = 7'h20;
			3'h2: v = full ? 7'h18 : 7'h08;
			3'h4, 3'h5: v = 7'h04;
			3'h6: v = full ? 7'h03 : 7'h01;
			default: v = 7'h00;
		endcase
		v = v & {{4{io}}, {3{mem}}};
		return ~v;
	endfunction : exp_cmd

	task automatic run_cycle(input logic [2:0] c, input logic gr, input logic en,
		input logic cx);
		int   n;
		logic io;
		io = en & (gr | !sysm);
		n = 0;
		cpu.issue(c);
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end while (als !== 1'b1 && n < 12);
		chk((c == 3'h7) ? (n == 12) : (n < 12), "latch strobe");
		if (sysm && cx) chk(cpe === (c == 3'h0), "cascade enable");
		if (sysm && cx) chk(cpm === (c == 3'h0 && cpu.ack_second), "masked cascade");
		@(posedge clk_in);
		#1;
		chk(als === 1'b0, "latch strobe width");
		chk(cmd_n === exp_cmd(c, 1'b0, en & gr, io), "early strobes");
		@(posedge clk_in);
		#1;
		chk(cmd_n === exp_cmd(c, 1'b1, en & gr, io), "strobes");
		chk(ioe === (gr | !sysm) && moe === gr, "drive enables");
		if (cx && c != 3'h0 && c != 3'h3 && c != 3'h7)
			chk(dir === (c == 3'h2 || c == 3'h6) && xen === (sysm | c[2]), "xcvr");
		if (!sysm) chk(cpe === !(en && c inside {3'h0, 3'h1, 3'h2}), "periph");
		cpu.passive();
		repeat (3) @(posedge clk_in);
		#1;
		chk(cmd_n === 7'h7F, "strobes released");
	endtask : run_cycle

	task automatic do_reset(input logic s);
		@(posedge clk_in);
		rstn_in <= 1'b0;
		strap <= !s;
		sysm = s;
		repeat (10) @(posedge clk_in);
		chk(cmd_n === 7'h7F && moe === 1'b0 && ioe === 1'b0 && als === 1'b0, "reset");
		chk(xen === 1'b0 && dir === 1'b1 && cpe === 1'b0, "reset controls");
		rstn_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		$display("test reset done");
	endtask : do_reset

	// ==========================================
	// Scenarios
	task automatic t_grant();
		int n;
		run_cycle(3'h5, 1'b0, 1'b1, 1'b0);
		run_cycle(3'h1, 1'b0, 1'b1, 1'b0);
		n = 0;
		cpu.grant(1'b1);
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end while (moe !== 1'b1 && n < 40);
		chk(n >= 11 && n <= 25, "grant delay");
		$display("test grant done");
	endtask : t_grant

	task automatic t_decode();
		for (int i = 0; i < 9; i++)
			run_cycle((i == 0) ? 3'h0 : 3'(i - 1), 1'b1, 1'b1, 1'b1);
		$display("test decode done");
	endtask : t_decode

	task automatic t_qualify();
		@(posedge clk_in);
		cq <= 1'b0;
		repeat (3) @(posedge clk_in);
		run_cycle(3'h5, 1'b1, 1'b0, 1'b0);
		run_cycle(3'h2, 1'b1, 1'b0, 1'b0);
		@(posedge clk_in);
		cq <= 1'b1;
		repeat (3) @(posedge clk_in);
		$display("test qualify done");
	endtask : t_qualify

	task automatic t_regs();
		ahb(`SBC_CTRL_OFFSET, 32'h0, 1'b0, rd);
		chk(rd === `SBC_CTRL_RESET, "ctrl reset value");
		ahb(`SBC_STATUS_OFFSET, 32'h0, 1'b0, rd);
		chk(rd[5:0] === {3'h2, 3'h7}, "status idle");
		ahb(32'h100, 32'hFFFF_FFFF, 1'b1, rd);
		ahb(32'h100, 32'h0, 1'b0, rd);
		chk(rd === 32'h0, "unmapped read");
		ahb(`SBC_CTRL_OFFSET, 32'h0, 1'b1, rd);
		run_cycle(3'h6, 1'b1, 1'b0, 1'b0);
		ahb(`SBC_CTRL_OFFSET, 32'h1, 1'b1, rd);
		ahb(`SBC_CTRL_OFFSET, 32'h0, 1'b0, rd);
		chk(rd === 32'h1, "ctrl readback");
		run_cycle(3'h4, 1'b1, 1'b1, 1'b1);
		$display("test registers done");
	endtask : t_regs

	task automatic t_release();
		int n;
		n = 0;
		cpu.grant(1'b0);
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end while (moe !== 1'b0 && n < 8);
		chk(n <= 4 && ioe === 1'b0, "grant release float");
		$display("test release done");
	endtask : t_release

	task automatic t_io();
		do_reset(1'b0);
		ahb(`SBC_STATUS_OFFSET, 32'h0, 1'b0, rd);
		chk(rd[3] === 1'b1, "io mode flag");
		run_cycle(3'h1, 1'b0, 1'b1, 1'b1);
		run_cycle(3'h2, 1'b0, 1'b1, 1'b1);
		run_cycle(3'h0, 1'b0, 1'b1, 1'b1);
		run_cycle(3'h5, 1'b0, 1'b1, 1'b0);
		cpu.grant(1'b1);
		repeat (20) @(posedge clk_in);
		run_cycle(3'h6, 1'b1, 1'b1, 1'b1);
		$display("test io mode done");
	endtask : t_io

	initial
	begin
		#200000;
		n_errors++;
		$display("ERROR %0t watchdog expired", $time);
		finish_test();
	end

	initial
	begin
		do_reset(1'b1);
		t_grant();
		t_decode();
		t_qualify();
		t_regs();
		t_release();
		t_io();
		finish_test();
	end
endmodule : test_cpu_status_bus_command_controller
